// ### verilog/vcu_defines.svh
/*
 * Constants for the voltage comparator control block: reset values,
 * synchroniser depth and edge mode encodings.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VCU_DEFINES_SVH
`define VCU_DEFINES_SVH

// Edge mode field encodings
`define VCU_MODE_FALL0 2'h0
`define VCU_MODE_RISE 2'h1
`define VCU_MODE_FALL2 2'h2
`define VCU_MODE_BOTH 2'h3

// Reset values of control and status
`define VCU_RST_MODE 2'h0
`define VCU_RST_BIT 1'h0

// Synchroniser depth
`define VCU_SYNC_STAGES 2

`endif

// ### verilog/vcu_pkg.sv
/*
 * Types for the voltage comparator control block.
 * Assumes nothing of its surroundings.
 */
package vcu_pkg;

	// Power state of the microcontroller as seen by the block
	typedef enum logic [4:0] {
		VCU_PWR_RUN = 5'h01,
		VCU_PWR_WAIT = 5'h02,
		VCU_PWR_STOP3 = 5'h04,
		VCU_PWR_DEEP = 5'h08,
		VCU_PWR_DEBUG = 5'h10
	} vcu_pwr_t;

endpackage : vcu_pkg

// ### verilog/vcu_evt_if.sv
/*
 * Interface carrying synchronised comparator result and edge events
 * between the edge detector and the control top.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface vcu_evt_if;
	logic live;
	logic rise;
	logic fall;
	logic run;

	modport det (input run, output live, output rise, output fall);
	modport ctl (output run, input live, input rise, input fall);
endinterface : vcu_evt_if

// ### verilog/vcu_edge_det.sv
/*
 * Two-stage synchroniser and edge detector for the comparator output.
 * Assumes the raw result is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "vcu_defines.svh"
module vcu_edge_det
	import vcu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic raw_result,
	vcu_evt_if.det evt
);
	logic [`VCU_SYNC_STAGES-1:0] sync;
	logic last;

	////////////////////////////////////////////////////////////////
	// Synchroniser; only stage two is looked at
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sync <= '0;
		end else begin
			sync <= {sync[0], raw_result};
		end
	end

	// Last sampled level, forced low while idle so no stale edge appears
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !evt.run) begin
			last <= 1'b0;
		end else begin
			last <= sync[1];
		end
	end

	// Edges only while running; a disabled module sees none
	assign evt.live = evt.run & sync[1];
	assign evt.rise = evt.run & sync[1] & ~last;
	assign evt.fall = evt.run & ~sync[1] & last;
endmodule : vcu_edge_det

// ### verilog/vcu_mode_dec.sv
/*
 * Edge mode decoder: picks which comparator edges count as events.
 * Assumes rise and fall are one-cycle pulses.
 */
`timescale 1ns/1ps
`include "vcu_defines.svh"
module vcu_mode_dec
	import vcu_pkg::*;
(
	input wire logic [1:0] mode,
	input wire logic rise,
	input wire logic fall,
	output logic event_hit
);
	// Decode used once for both edge kinds together
	function automatic logic vcu_hit(input logic [1:0] m, input logic r, input logic f);
		logic h;
		h = 1'b0;
		if (m == `VCU_MODE_RISE) begin
			h = r;
		end else if (m == `VCU_MODE_BOTH) begin
			h = r | f;
		end else begin
			h = f; // Both 00 and 10 mean falling
		end
		return h;
	endfunction : vcu_hit

	assign event_hit = vcu_hit(mode, rise, fall);
endmodule : vcu_mode_dec

// ### verilog/vcu_top.sv
/*
 * Control and event logic around an on-chip voltage comparator unit.
 * Holds enable, reference select, edge mode, flag, interrupt, pin
 * output and timer capture routing. Assumes the analog comparator
 * result arrives as an asynchronous level, and the power controller
 * reports the power state each cycle.
 */
// Summary of operation
// - Route result into timer one channel zero capture.
// - Routing hides the timer channel zero pin.
// - Interrupt on rising, falling, or either edge.
// - Option to show result on output pin.
// - Enabled comparator keeps running in wait.
// - Wait wake only with interrupt enable set.
// - Keeps comparing in lightest stop mode.
// - Output pin driven in lightest stop too.
// - Stop event sets flag, wakes if enabled.
// - Reset exit from stop resets all bits.
// - Deeper stops power the module down.
// - Wake from deeper stop finds reset state.
// - Keeps operating normally in background debug.
// - Negative pin always feeds inverting input.
// - Select zero uses positive pin, else bandgap.
// - Single result pin, driven only when enabled.
// - Mode 00/10 fall, 01 rise, 11 both.
// - Flag sets on event, clears on write-one.
// - Interrupt request while flag and enable set.
`timescale 1ns/1ps
`include "vcu_defines.svh"
module vcu_top
	import vcu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [4:0] power_state,
	input wire logic raw_result,
	input wire logic timer_ch0_pin_in,
	input wire logic module_enable_wr,
	input wire logic module_enable_in,
	input wire logic reference_select_wr,
	input wire logic reference_select_in,
	input wire logic compare_irq_enable_wr,
	input wire logic compare_irq_enable_in,
	input wire logic result_pin_enable_wr,
	input wire logic result_pin_enable_in,
	input wire logic edge_mode_select_wr,
	input wire logic [1:0] edge_mode_select_in,
	input wire logic result_to_capture_route_wr,
	input wire logic result_to_capture_route_in,
	input wire logic flag_clear_wr,
	output logic module_enable,
	output logic reference_select,
	output logic compare_irq_enable,
	output logic result_pin_enable,
	output logic [1:0] edge_mode_select,
	output logic result_to_capture_route,
	output logic compare_event_flag,
	output logic live_result_bit,
	output logic compare_irq,
	output logic wake_request,
	output logic compare_result_pin,
	output logic compare_result_pin_oe_n,
	output logic timer_ch0_capture_in,
	output logic timer_ch0_pin_avail,
	output logic analog_powered,
	output logic analog_bandgap_sel,
	output logic analog_neg_to_inverting
);
	vcu_pwr_t pwr;
	logic deep;
	logic event_hit;
	logic next_flag;
	vcu_evt_if evt ();

	assign pwr = vcu_pwr_t'(power_state);
	assign deep = (pwr == VCU_PWR_DEEP);
	// Event path runs in run, wait, lightest stop and debug alike
	assign evt.run = module_enable & ~deep;

	vcu_edge_det u_det (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.raw_result(raw_result),
		.evt(evt)
	);

	vcu_mode_dec u_dec (
		.mode(edge_mode_select),
		.rise(evt.rise),
		.fall(evt.fall),
		.event_hit(event_hit)
	);

	////////////////////////////////////////////////////////////////
	// Control bits; deep stop loses all state, so wake finds reset values
	always_ff @(posedge clk_sys) begin
		if (!reset_n || deep) begin
			module_enable <= `VCU_RST_BIT;
			reference_select <= `VCU_RST_BIT;
			compare_irq_enable <= `VCU_RST_BIT;
			result_pin_enable <= `VCU_RST_BIT;
			edge_mode_select <= `VCU_RST_MODE;
			result_to_capture_route <= `VCU_RST_BIT;
		end else begin
			if (module_enable_wr) begin
				module_enable <= module_enable_in;
			end
			if (reference_select_wr) begin
				reference_select <= reference_select_in;
			end
			if (compare_irq_enable_wr) begin
				compare_irq_enable <= compare_irq_enable_in;
			end
			if (result_pin_enable_wr) begin
				result_pin_enable <= result_pin_enable_in;
			end
			if (edge_mode_select_wr) begin
				edge_mode_select <= edge_mode_select_in;
			end
			if (result_to_capture_route_wr) begin
				result_to_capture_route <= result_to_capture_route_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Flag: a new event beats a write-one clear in the same cycle
	assign next_flag = event_hit | (compare_event_flag & ~flag_clear_wr);

	always_ff @(posedge clk_sys) begin
		if (!reset_n || deep) begin
			compare_event_flag <= `VCU_RST_BIT;
		end else begin
			compare_event_flag <= next_flag;
		end
	end

	// Interrupt and wake are registered from next_flag, so they change in the same cycle as the flag
	always_ff @(posedge clk_sys) begin
		if (!reset_n || deep) begin
			compare_irq <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			compare_irq <= next_flag & compare_irq_enable;
			wake_request <= next_flag & compare_irq_enable
				& (pwr == VCU_PWR_WAIT || pwr == VCU_PWR_STOP3);
		end
	end

	////////////////////////////////////////////////////////////////
	// Live result, pin and capture routing
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			live_result_bit <= 1'b0;
			compare_result_pin <= 1'b0;
			compare_result_pin_oe_n <= 1'b1;
			timer_ch0_capture_in <= 1'b0;
			timer_ch0_pin_avail <= 1'b1;
		end else begin
			live_result_bit <= evt.live;
			compare_result_pin <= evt.live;
			// Pin drives in run and lightest stop alike
			compare_result_pin_oe_n <= ~(result_pin_enable & evt.run);
			// Comparator replaces the pin at the capture input
			timer_ch0_capture_in <= result_to_capture_route
				? evt.live : timer_ch0_pin_in;
			timer_ch0_pin_avail <= ~result_to_capture_route | deep;
		end
	end

	// Analog steering; bandgap buffer itself is software's job elsewhere
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			analog_powered <= 1'b0;
			analog_bandgap_sel <= 1'b0;
			analog_neg_to_inverting <= 1'b1;
		end else begin
			analog_powered <= evt.run;
			analog_bandgap_sel <= reference_select;
			analog_neg_to_inverting <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	// Flag and interrupt request
	a_flag_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
		event_hit && !deep |=> compare_event_flag)
		else $error("flag missed an event");
	a_flag_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
		compare_event_flag && flag_clear_wr && !event_hit |=> !compare_event_flag)
		else $error("flag ignored write-one clear");
	a_flag_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
		compare_event_flag && !flag_clear_wr && !deep |=> compare_event_flag)
		else $error("flag dropped by itself");
	a_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
		event_hit && flag_clear_wr |=> compare_event_flag)
		else $error("clear beat a new event");
	a_irq_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> compare_irq == ($past(next_flag) && $past(compare_irq_enable)
			&& !$past(deep)))
		else $error("irq mismatch");
	a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!compare_event_flag && !event_hit |=> !compare_irq)
		else $error("irq without a flag");

	// Edge mode decode
	a_rise_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		evt.rise && edge_mode_select == `VCU_MODE_RISE |-> event_hit)
		else $error("rise not taken");
	a_fall_ign: assert property (@(posedge clk_sys) disable iff (!reset_n)
		evt.fall && edge_mode_select == `VCU_MODE_RISE |-> !event_hit)
		else $error("fall taken in rise mode");
	a_fall_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		evt.fall && edge_mode_select != `VCU_MODE_RISE |-> event_hit)
		else $error("fall not taken");
	a_both_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(evt.rise || evt.fall) && edge_mode_select == `VCU_MODE_BOTH |-> event_hit)
		else $error("edge missed in either-edge mode");
	a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!module_enable |-> !event_hit)
		else $error("event while disabled");

	// Power modes
	a_wait_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_WAIT && module_enable |-> evt.run)
		else $error("event path stopped in wait");
	a_stop_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_STOP3 && module_enable |-> evt.run)
		else $error("event path stopped in light stop");
	a_debug_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_DEBUG && module_enable |-> evt.run)
		else $error("event path stopped in debug");
	a_wake_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!compare_irq_enable |=> !wake_request)
		else $error("wake without interrupt enable");
	a_wake_run_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_RUN || pwr == VCU_PWR_DEBUG |=> !wake_request)
		else $error("wake while not asleep");
	a_wait_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_WAIT && event_hit && compare_irq_enable |=> wake_request)
		else $error("no wake from wait");
	a_stop_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_STOP3 && event_hit && compare_irq_enable |=> wake_request)
		else $error("no wake from light stop");
	a_deep_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		deep |=> !module_enable && !compare_event_flag && !compare_irq)
		else $error("deep stop kept state");
	a_deep_modes: assert property (@(posedge clk_sys) disable iff (!reset_n)
		deep |=> edge_mode_select == `VCU_RST_MODE && !result_pin_enable
			&& !result_to_capture_route)
		else $error("deep stop kept configuration");
	a_deep_unpowered: assert property (@(posedge clk_sys) disable iff (!reset_n)
		deep |=> !analog_powered && compare_result_pin_oe_n)
		else $error("powered in deep stop");

	// Live bit, result pin and capture routing
	a_live_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!module_enable ##1 !module_enable |-> !live_result_bit)
		else $error("live bit set while disabled");
	a_live_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> live_result_bit == $past(evt.live))
		else $error("live bit lost the result");
	a_pin_oe: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!result_pin_enable |=> compare_result_pin_oe_n)
		else $error("pin driven while disabled");
	a_pin_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
		result_pin_enable && module_enable && !deep |=> !compare_result_pin_oe_n)
		else $error("pin not driven while enabled");
	a_pin_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> compare_result_pin == $past(evt.live))
		else $error("pin shows a wrong result");
	a_route_cap: assert property (@(posedge clk_sys) disable iff (!reset_n)
		result_to_capture_route && !deep |=> !timer_ch0_pin_avail)
		else $error("pin available while routed");
	a_pin_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!result_to_capture_route |=> timer_ch0_pin_avail)
		else $error("pin hidden while not routed");
	a_route_result: assert property (@(posedge clk_sys) disable iff (!reset_n)
		result_to_capture_route |=> timer_ch0_capture_in == $past(evt.live))
		else $error("capture missed the result");
	a_route_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!result_to_capture_route |=> timer_ch0_capture_in == $past(timer_ch0_pin_in))
		else $error("capture missed the pin");

	// Analog steering
	a_neg_fixed: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> analog_neg_to_inverting)
		else $error("negative input disconnected");
	a_ref_steer: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> analog_bandgap_sel == $past(reference_select))
		else $error("reference steering wrong");

	// Main scenarios worth seeing
	c_event_stop3: cover property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_STOP3 && event_hit ##1 wake_request);
	c_wait_wake: cover property (@(posedge clk_sys) disable iff (!reset_n)
		pwr == VCU_PWR_WAIT && event_hit ##1 wake_request);
	c_both_edges: cover property (@(posedge clk_sys) disable iff (!reset_n)
		edge_mode_select == `VCU_MODE_BOTH && evt.fall && event_hit);
	c_clear_race: cover property (@(posedge clk_sys) disable iff (!reset_n)
		event_hit && flag_clear_wr);
	c_routed: cover property (@(posedge clk_sys) disable iff (!reset_n)
		result_to_capture_route && evt.rise);
endmodule : vcu_top

// ### verification/vcu_analog_side.sv
/*
 * Far-side model: analog input pins, bandgap and comparator output.
 * Assumes levels in millivolts set by the bench, sampled on clk_sys.
 */
`timescale 1ns/1ps
module vcu_analog_side #(
	parameter int BG_MV = 1200
) (
	input wire logic clk_sys,
	input wire logic powered,
	input wire logic bandgap_sel,
	input wire logic neg_to_inverting,
	input var int pos_mv,
	input var int neg_mv,
	output logic raw_result
);
	initial raw_result = 1'h0;
	////////////////////////////////////////////////////////////////////////////////
	// Unpowered output wanders each cycle so a stale level never looks valid
	always @(posedge clk_sys) begin
		if (!powered) begin
			raw_result <= !raw_result;
		end else if (bandgap_sel) begin
			raw_result <= (BG_MV > neg_mv) && neg_to_inverting;
		end else begin
			raw_result <= (pos_mv > neg_mv) && neg_to_inverting;
		end
	end
endmodule : vcu_analog_side

// ### verification/vcu_top_bench.sv
/*
 * Self-checking bench for vcu_top against a reference model.
 * Assumes the far-side model vcu_analog_side.
 */
`timescale 1ns/1ps
module vcu_top_bench;
	localparam int BG = 1200;
	logic clk_sys = 0, reset_n = 0, raw_result, pin = 0, fclr = 0;
	logic [4:0] ps = 5'h01;
	logic [6:0] wr = 0, din = 0, e = 0;
	logic ef = 0, res = 0, hit, nr, pwr, bgs, neg_in;
	logic me, rs, ie, pe, rt, flg, live, irq, wake, rpin, oe_n, cap, avail;
	logic [1:0] md;
	int pos = 0, neg = 1500, n_fail = 0, n_tests = 0;

	vcu_top u_vcu_top (.clk_sys(clk_sys), .reset_n(reset_n), .power_state(ps),
		.raw_result(raw_result), .timer_ch0_pin_in(pin),
		.module_enable_wr(wr[0]), .module_enable_in(din[0]),
		.reference_select_wr(wr[1]), .reference_select_in(din[1]),
		.compare_irq_enable_wr(wr[2]), .compare_irq_enable_in(din[2]),
		.result_pin_enable_wr(wr[3]), .result_pin_enable_in(din[3]),
		.edge_mode_select_wr(wr[4]), .edge_mode_select_in(din[5:4]),
		.result_to_capture_route_wr(wr[6]), .result_to_capture_route_in(din[6]),
		.flag_clear_wr(fclr), .module_enable(me), .reference_select(rs),
		.compare_irq_enable(ie), .result_pin_enable(pe), .edge_mode_select(md),
		.result_to_capture_route(rt), .compare_event_flag(flg), .live_result_bit(live),
		.compare_irq(irq), .wake_request(wake), .compare_result_pin(rpin),
		.compare_result_pin_oe_n(oe_n), .timer_ch0_capture_in(cap),
		.timer_ch0_pin_avail(avail), .analog_powered(pwr), .analog_bandgap_sel(bgs),
		.analog_neg_to_inverting(neg_in));
	vcu_analog_side #(.BG_MV(BG)) u_vcu_analog_side (.clk_sys(clk_sys), .powered(pwr),
		.bandgap_sel(bgs), .neg_to_inverting(neg_in), .pos_mv(pos), .neg_mv(neg),
		.raw_result(raw_result));

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz
	always #2.5 clk_sys = !clk_sys;

	function automatic logic cmp_r();
		return e[1] ? (BG > neg) : (pos > neg);
	endfunction : cmp_r

	task automatic ck(logic [6:0] got, logic [6:0] exp, string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : ck

	task automatic finish_test();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Enough edges for sync, flag and registered outputs to land
	task automatic settle();
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : settle

	// One write strobe; writes in deep stop are dropped by the model too
	task automatic wr_ctl(int i, logic [1:0] v);
		@(posedge clk_sys);
		#1 wr[i] = 1;
		din[i] = v[0];
		if (i == 4) din[5:4] = v;
		if (ps != 5'h08) e[i] = v[0];
		if (ps != 5'h08 && i == 4) e[5:4] = v;
		@(posedge clk_sys);
		#1 wr[i] = 0;
	endtask : wr_ctl

	task automatic clr();
		@(posedge clk_sys);
		#1 fclr = 1;
		@(posedge clk_sys);
		#1 fclr = 0;
		ef = 0;
	endtask : clr

	task automatic chk();
		ck({rt, md, pe, ie, rs, me}, e, "ctl");
		ck(flg, ef, "flag");
		ck(live, e[0] && cmp_r(), "live");
		ck(irq, ef && e[2], "irq");
		ck(wake, ef && e[2] && (ps == 5'h02 || ps == 5'h04), "wake");
		ck(avail, !e[6], "avail");
		if (ps == 5'h08) ck({pwr, oe_n}, 7'h1, "deep");
		else ck({pwr, neg_in, bgs}, {e[0], 1'b1, e[1]}, "steer");
		ck(oe_n, !(e[0] && e[3]), "oe");
		if (e[0]) begin
			if (e[3]) ck(rpin, cmp_r(), "pin");
			ck(cap, e[6] ? cmp_r() : pin, "cap");
		end
	endtask : chk

	// Settle after a config change, then start from a clean flag
	task automatic sync_up();
		settle();
		clr();
		settle();
		res = cmp_r();
		chk();
	endtask : sync_up

	// New analog levels; the model predicts the event from the edge mode
	task automatic apply(int p, int n);
		@(posedge clk_sys);
		#1 pos = p;
		neg = n;
		nr = cmp_r();
		case (e[5:4])
			2'h1: hit = !res && nr;
			2'h3: hit = res != nr;
			default: hit = res && !nr;
		endcase
		if (e[0] && ps != 5'h08 && hit) ef = 1;
		res = nr;
		settle();
		chk();
	endtask : apply

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 800 cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		finish_test();
	end

	// Main sequence
	initial begin
		void'($urandom(32'habb36085));
		repeat (16) @(posedge clk_sys);
		#1 reset_n = 1;
		chk();
		wr_ctl(0, 2'h1);
		wr_ctl(2, 2'h1);
		wr_ctl(3, 2'h1);
		sync_up();
		for (int i = 0; i < 64; i++) begin
			if (i % 4 == 0) wr_ctl(4, 2'(i / 4));
			// Interrupt stays enabled, so the comparator is kept as a wake source
			ps = (i >= 48) ? 5'h10 : 5'(1 << (i / 16));
			if (i == 8) wr_ctl(6, 2'h1);
			if (i == 32) begin
				wr_ctl(1, 2'h1);
				sync_up();
			end
			pin = 1'($urandom);
			if (i % 3 == 0) clr();
			apply(int'($urandom_range(3000)), int'($urandom_range(3000)));
		end
		// Disabled: edges ignored and live bit reads zero
		wr_ctl(0, 2'h0);
		apply(0, 2500);
		wr_ctl(0, 2'h1);
		sync_up();
		// Deep stop clears everything and refuses writes
		ps = 5'h08;
		e = 0;
		ef = 0;
		settle();
		wr_ctl(0, 2'h1);
		apply(2000, 100);
		ps = 5'h01;
		settle();
		chk();
		// Reset in mid-run
		wr_ctl(0, 2'h1);
		wr_ctl(2, 2'h1);
		sync_up();
		apply(0, 100);
		reset_n = 0;
		e = 0;
		ef = 0;
		repeat (2) @(posedge clk_sys);
		#1 reset_n = 1;
		settle();
		chk();
		finish_test();
	end
endmodule : vcu_top_bench
